// *** rtl/imrs_pkg.sv ***
// Purpose: shared constants and types for the two-wire read sequencer
// Assumes: 10 MHz core clock, APB register access
// Notes:   struct fields are listed msb first
package imrs_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_DATA  = 8'h00; // tx write / rx read
  localparam logic [7:0] OFF_CTRL  = 8'h04; // control bits
  localparam logic [7:0] OFF_STAT  = 8'h08; // status, read only
  localparam logic [7:0] OFF_DIV   = 8'h0C; // quarter-bit divider
  localparam logic [7:0] OFF_ISTAT = 8'h10; // sticky events, w1c
  localparam logic [7:0] OFF_IMASK = 8'h14; // event mask
  // ----------------------------------------------------------------
  // reset values and widths
  // ----------------------------------------------------------------
  localparam int         NUM_EV    = 4;     // interrupt events
  localparam logic [15:0] DIV_RST  = 16'h0019; // 100 kbit/s
  localparam logic [3:0] EV_RX     = 4'h1;  // event bit: byte received
  localparam logic [3:0] EV_NACK   = 4'h2;  // event bit: not-acknowledge
  localparam logic [3:0] EV_TX     = 4'h4;  // event bit: data reg taken
  localparam logic [3:0] EV_STOP   = 4'h8;  // event bit: stop sent
  localparam logic [3:0] LAST_BIT  = 4'h8;  // ack slot index
  // ----------------------------------------------------------------
  // timing: fastest allowed bus rate
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 100;        // core clock period
  localparam int MAX_KBPS     = 400;        // bus rate ceiling
  localparam int BIT_MIN_NS   = 1000000 / MAX_KBPS;
  localparam logic [15:0] QDIV_MIN =
    16'((BIT_MIN_NS + 4 * CLK_NS - 1) / (4 * CLK_NS));
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rd10;          // 10-bit read: auto restart after 2nd byte
    logic tx_irq_enable; // report data register taken
    logic nack_next;     // answer next received byte with nack
    logic stop;          // request stop condition
    logic start;         // request (repeated) start
    logic enable;        // controller on
  } imrs_ctrl_t;
  typedef struct packed {
    logic rx_mode;           // receiving bytes
    logic busy;              // not idle
    logic nack_irq_flag;     // not-acknowledge seen or sent
    logic ack_stat;          // last address/data byte acknowledged
    logic tx_empty;          // data register free for writing
    logic rx_data_full_flag; // received byte waiting
  } imrs_stat_t;
  typedef enum logic [2:0] {S_IDLE, S_START, S_RSTART, S_BIT, S_WAIT, S_STOP}
    imrs_state_t;
endpackage

// *** rtl/imrs_top.sv ***
// Purpose: master-only two-wire controller for read sequences
// Assumes: open-drain pins resolved outside; APB slave, zero wait
// Notes:   scl and sda pass two flops before use
// Operation
// - shift byte in, ack unless nack-next set
// - completed byte sets receive-full flag
// - data register read clears receive-full flag
// - bytes repeat without new start or address
// - nacked last byte sets nack flag
// - stop request sends stop, clears stop, nack
// - 10-bit first byte is 11110, a9a8, write
// - start condition precedes any address bit
// - after start, data register loads shifter
// - slave nack sets flag, clears ack status
// - master only, at most 400 kbit/s
`timescale 1ns/1ns
module imrs_top
  import imrs_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // apb slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic            pready,
  output logic [31:0]     prdata,
  output logic            pslverr,
  // two-wire bus pins
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  // interrupt
  output logic            irq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  imrs_ctrl_t    ctrl;          // control register
  imrs_stat_t    stat;          // status view
  imrs_state_t   state;         // sequencer state
  logic [15:0]   div;           // divider setting
  logic [15:0]   qdiv;          // divider clamped to rate ceiling
  logic [15:0]   divcnt;        // divider count
  logic          tick;          // quarter-bit enable
  logic          tick_go;       // tick not held by slave stretch
  logic [1:0]    q;             // quarter within bit
  logic [3:0]    bitcnt;        // bit within byte, 8 is ack slot
  logic [7:0]    shift;         // shift register
  logic [7:0]    first_byte;    // first address byte kept for restart
  logic [7:0]    tx_data;       // data register, write side
  logic [7:0]    rx_data;       // data register, read side
  logic          tx_full;       // tx_data not yet taken
  logic          rx_mode;       // receiving
  logic [1:0]    addr_cnt;      // acked bytes since start
  logic          rs_auto;       // restart made by hardware
  logic          nack_sent;     // we answered nack
  logic          got_nack;      // slave answered nack
  logic          scl_meta;      // sync stage 1
  logic          scl_s;         // synced scl
  logic          sda_meta;      // sync stage 1
  logic          sda_s;         // synced sda
  logic          wr;            // apb write completes
  logic          rd;            // apb read completes
  logic          hit;           // address mapped
  logic          byte_end;      // byte slot finished
  logic          rx_done;       // received byte finished
  logic          nack_evt;      // nack event
  logic          auto_rs;       // 10-bit restart due
  logic          to_rx;         // read address acked
  logic          tx_take;       // data register taken
  logic          start_take;    // start request taken
  logic          stop_done;     // stop finished
  logic [3:0]    istat;         // sticky events
  logic [3:0]    imask;         // event mask
  logic [3:0]    ev;            // events this cycle
  logic [15:0]   gap;           // cycles since last tick
  logic          rx_data_full_flag; // received byte waiting
  logic          nack_irq_flag;     // nack seen or sent
  logic          ack_stat;          // last sent byte acknowledged

  // pins drive low only
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_meta <= 1'b1;
      scl_s    <= 1'b1;
      sda_meta <= 1'b1;
      sda_s    <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      scl_s    <= scl_meta;
      sda_meta <= sda_i;
      sda_s    <= sda_meta;
    end
  end

  // ----------------------------------------------------------------
  // quarter-bit divider
  // ----------------------------------------------------------------
  assign qdiv = (div < QDIV_MIN) ? QDIV_MIN : div;
  assign tick = (divcnt >= qdiv - 16'h0001);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      divcnt <= 16'h0000;
    else if (tick)
      divcnt <= 16'h0000;
    else
      divcnt <= divcnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // sequencer event terms
  // ----------------------------------------------------------------
  always_comb
  begin
    // slave may stretch scl while we wait for it high
    tick_go  = tick && !((q == 2'd2) && !scl_s
               && (state == S_BIT || state == S_RSTART || state == S_STOP));
    byte_end = tick_go && state == S_BIT && q == 2'd3 && bitcnt == LAST_BIT;
    rx_done  = byte_end && rx_mode;
    nack_evt = (byte_end && !rx_mode && got_nack)
               || (rx_done && nack_sent);
    auto_rs  = byte_end && !rx_mode && !got_nack && ctrl.rd10
               && addr_cnt == 2'd1;
    to_rx    = byte_end && !rx_mode && !got_nack && addr_cnt == 2'd0
               && first_byte[0];
    start_take = tick_go && ctrl.start && ((state == S_IDLE)
                 || (state == S_WAIT && !ctrl.stop));
    stop_done  = tick_go && state == S_STOP && q == 2'd3;
    tx_take  = (tick_go && q == 2'd3 && (state == S_START
               || (state == S_RSTART && !rs_auto)))
               || (byte_end && !rx_mode && !got_nack && !auto_rs && !to_rx
                   && tx_full)
               || (tick_go && state == S_WAIT && !ctrl.stop && !ctrl.start
                   && !rx_mode && !got_nack && tx_full);
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_IDLE;
      q <= 2'd0;
      bitcnt <= 4'h0;
      shift <= 8'h00;
      first_byte <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rx_mode <= 1'b0;
      addr_cnt <= 2'd0;
      rs_auto <= 1'b0;
      nack_sent <= 1'b0;
      got_nack <= 1'b0;
    end
    else if (!ctrl.enable)
    begin
      // disabled: release the bus
      state <= S_IDLE;
      q <= 2'd0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (tick_go)
    begin
      q <= q + 2'd1;
      case (state)
        S_IDLE:
        begin
          q <= 2'd0;
          if (ctrl.start)
          begin
            state <= S_START;
            rx_mode <= 1'b0;
            addr_cnt <= 2'd0;
            rs_auto <= 1'b0;
            nack_sent <= 1'b0;
            got_nack <= 1'b0;
          end
        end
        S_START:
        begin
          // sda falls while scl high before any address bit
          if (q == 2'd2)
            sda_oe <= 1'b1;
          else if (q == 2'd3)
          begin
            scl_oe <= 1'b1;
            shift <= tx_data;
            first_byte <= tx_data;
            bitcnt <= 4'h0;
            state <= S_BIT;
          end
        end
        S_RSTART:
        begin
          // restart: release sda, raise scl, pull sda, pull scl
          if (q == 2'd0)
            sda_oe <= 1'b0;
          else if (q == 2'd1)
            scl_oe <= 1'b0;
          else if (q == 2'd2)
            sda_oe <= 1'b1;
          else
          begin
            scl_oe <= 1'b1;
            shift <= rs_auto ? {first_byte[7:1], 1'b1} : tx_data;
            first_byte <= rs_auto ? {first_byte[7:1], 1'b1} : tx_data;
            addr_cnt <= 2'd0;
            rx_mode <= 1'b0;
            nack_sent <= 1'b0;
            got_nack <= 1'b0;
            bitcnt <= 4'h0;
            state <= S_BIT;
          end
        end
        S_BIT:
        begin
          if (q == 2'd0)
          begin
            // set data while scl low
            if (bitcnt == LAST_BIT)
            begin
              sda_oe <= rx_mode && !ctrl.nack_next;
              nack_sent <= rx_mode && ctrl.nack_next;
            end
            else
              sda_oe <= !rx_mode && !shift[7];
          end
          else if (q == 2'd1)
            scl_oe <= 1'b0;
          else if (q == 2'd2)
          begin
            // sample with scl high
            if (bitcnt == LAST_BIT)
              got_nack <= sda_s;
            else
              shift <= {shift[6:0], sda_s};
          end
          else
          begin
            scl_oe <= 1'b1;
            if (bitcnt != LAST_BIT)
              bitcnt <= bitcnt + 4'h1;
            else
            begin
              bitcnt <= 4'h0;
              if (rx_mode || got_nack)
                state <= S_WAIT;
              else
              begin
                if (addr_cnt != 2'd3)
                  addr_cnt <= addr_cnt + 2'd1;
                if (auto_rs)
                begin
                  rs_auto <= 1'b1;
                  state <= S_RSTART;
                end
                else if (to_rx)
                  rx_mode <= 1'b1;
                else if (tx_full)
                  shift <= tx_data;
                else
                  state <= S_WAIT;
              end
            end
          end
        end
        S_WAIT:
        begin
          // scl held low until software acts
          q <= 2'd0;
          sda_oe <= 1'b0;
          if (ctrl.stop)
            state <= S_STOP;
          else if (ctrl.start)
          begin
            rs_auto <= 1'b0;
            state <= S_RSTART;
          end
          else if (!rx_mode && !got_nack && tx_full)
          begin
            shift <= tx_data;
            state <= S_BIT;
          end
          else if (rx_mode && !stat.rx_data_full_flag && !nack_sent)
            state <= S_BIT;
        end
        S_STOP:
        begin
          // sda rises while scl high
          if (q == 2'd0)
            sda_oe <= 1'b1;
          else if (q == 2'd1)
            scl_oe <= 1'b0;
          else if (q == 2'd3)
          begin
            sda_oe <= 1'b0;
            rx_mode <= 1'b0;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb decode and control registers
  // ----------------------------------------------------------------
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign hit = (paddr == OFF_DATA) || (paddr == OFF_CTRL)
               || (paddr == OFF_STAT) || (paddr == OFF_DIV)
               || (paddr == OFF_ISTAT) || (paddr == OFF_IMASK);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= '0;
      div <= DIV_RST;
      tx_data <= 8'h00;
      tx_full <= 1'b0;
      imask <= 4'h0;
    end
    else
    begin
      // hardware clears first, a same-cycle write wins
      if (start_take)
        ctrl.start <= 1'b0;
      if (stop_done)
        ctrl.stop <= 1'b0;
      if (tx_take)
        tx_full <= 1'b0;
      if (wr && paddr == OFF_DATA)
      begin
        tx_data <= pwdata[7:0];
        tx_full <= 1'b1;
      end
      else if (wr && paddr == OFF_CTRL)
        ctrl <= pwdata[5:0];
      else if (wr && paddr == OFF_DIV)
        div <= pwdata[15:0];
      else if (wr && paddr == OFF_IMASK)
        imask <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // status flags and receive data
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_data_full_flag <= 1'b0;
      nack_irq_flag <= 1'b0;
      ack_stat <= 1'b0;
      rx_data <= 8'h00;
    end
    else
    begin
      if (rx_done)
      begin
        rx_data <= shift;
        rx_data_full_flag <= 1'b1;
      end
      else if (rd && paddr == OFF_DATA)
        rx_data_full_flag <= 1'b0;
      if (nack_evt)
        nack_irq_flag <= 1'b1;
      else if (stop_done)
        nack_irq_flag <= 1'b0;
      if (byte_end && !rx_mode)
        ack_stat <= !got_nack;
    end
  end
  // status view, one driver for the whole word, msb first
  assign stat = {rx_mode, (state != S_IDLE), nack_irq_flag, ack_stat, !tx_full,
                 rx_data_full_flag};

  // ----------------------------------------------------------------
  // interrupt status, w1c, set wins
  // ----------------------------------------------------------------
  assign ev = (rx_done ? EV_RX : 4'h0) | (nack_evt ? EV_NACK : 4'h0)
            | ((tx_take && ctrl.tx_irq_enable) ? EV_TX : 4'h0)
            | (stop_done ? EV_STOP : 4'h0);
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      istat <= 4'h0;
    else
      istat <= (istat & ~((wr && paddr == OFF_ISTAT) ? pwdata[3:0] : 4'h0)) | ev;
  end
  assign irq = |(istat & imask);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= !hit;
      if (paddr == OFF_DATA)
        prdata <= {24'h000000, rx_data};
      else if (paddr == OFF_CTRL)
        prdata <= {26'h0000000, ctrl};
      else if (paddr == OFF_STAT)
        prdata <= {26'h0000000, stat};
      else if (paddr == OFF_DIV)
        prdata <= {16'h0000, div};
      else if (paddr == OFF_ISTAT)
        prdata <= {28'h0000000, istat};
      else if (paddr == OFF_IMASK)
        prdata <= {28'h0000000, imask};
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      gap <= 16'h0000;
    else if (tick)
      gap <= 16'h0000;
    else if (gap != 16'hFFFF)
      gap <= gap + 16'h0001;
  end
  property p_rx_flag;
    @(posedge core_clk) disable iff (!rst_b)
    rx_done |=> stat.rx_data_full_flag && rx_data == $past(shift);
  endproperty
  a_rx_flag: assert property (p_rx_flag)
    else $error("received byte did not set full flag");
  property p_rd_clr;
    @(posedge core_clk) disable iff (!rst_b)
    (rd && paddr == OFF_DATA && !rx_done) |=> !stat.rx_data_full_flag;
  endproperty
  a_rd_clr: assert property (p_rd_clr)
    else $error("data read left full flag set");
  property p_ack_drive;
    @(posedge core_clk) disable iff (!rst_b)
    (state == S_BIT && bitcnt == LAST_BIT && q == 2'd2 && rx_mode)
      |-> sda_oe == !nack_sent;
  endproperty
  a_ack_drive: assert property (p_ack_drive)
    else $error("ack slot drive wrong");
  property p_rx_release;
    @(posedge core_clk) disable iff (!rst_b)
    (state == S_BIT && rx_mode && bitcnt != LAST_BIT && q != 2'd0) |-> !sda_oe;
  endproperty
  a_rx_release: assert property (p_rx_release)
    else $error("sda driven during receive bits");
  property p_nack_flag;
    @(posedge core_clk) disable iff (!rst_b)
    (rx_done && nack_sent) |=> stat.nack_irq_flag ##1 state == S_WAIT;
  endproperty
  a_nack_flag: assert property (p_nack_flag)
    else $error("nacked last byte did not flag");
  property p_slave_nack;
    @(posedge core_clk) disable iff (!rst_b)
    (byte_end && !rx_mode && got_nack) |=> stat.nack_irq_flag && !stat.ack_stat;
  endproperty
  a_slave_nack: assert property (p_slave_nack)
    else $error("slave nack not reported");
  property p_stop_end;
    @(posedge core_clk) disable iff (!rst_b)
    stop_done |=> !ctrl.stop && !stat.nack_irq_flag && !sda_oe && !scl_oe;
  endproperty
  a_stop_end: assert property (p_stop_end)
    else $error("stop did not clear flags");
  property p_sda_edge;
    @(posedge core_clk) disable iff (!rst_b)
    ($changed(sda_oe) && !scl_oe && ctrl.enable)
      |-> $past(state) inside {S_START, S_RSTART, S_STOP};
  endproperty
  a_sda_edge: assert property (p_sda_edge)
    else $error("sda moved while scl high outside start or stop");
  property p_load;
    @(posedge core_clk) disable iff (!rst_b)
    (state == S_START && tick_go && q == 2'd3) |=> shift == $past(tx_data);
  endproperty
  a_load: assert property (p_load)
    else $error("shifter not loaded after start");
  property p_restart;
    @(posedge core_clk) disable iff (!rst_b)
    auto_rs |=> state == S_RSTART && rs_auto;
  endproperty
  a_restart: assert property (p_restart)
    else $error("10-bit restart missing");
  property p_rate;
    @(posedge core_clk) disable iff (!rst_b)
    tick |-> gap >= QDIV_MIN - 16'h0001;
  endproperty
  a_rate: assert property (p_rate)
    else $error("bus rate above ceiling");
  c_rx: cover property (@(posedge core_clk) rx_done);
  c_stop: cover property (@(posedge core_clk) stop_done);
  c_rs: cover property (@(posedge core_clk) auto_rs);
endmodule // imrs_top

// *** bench/imrs_slave.sv ***
// Purpose: two-wire slave model that answers reads
// Assumes: both lines have pull-ups; this model never stretches the clock
// Notes:   own address 0x2A or 10-bit 0x2AA; byte k of a read is 0xA5 xor k
`timescale 1ns/1ns
module imrs_slave
(
  // resolved bus levels and our pull-down
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_pull,
  // first byte seen after the last start
  output logic [7:0]      addr_seen
);
  logic [7:0] sh; // address shifter
  logic [7:0] b;  // byte being sent
  int         i;  // bit index
  int         k;  // byte index
  // ------------------------------------------------------------
  // frame handling, one start at a time
  // ------------------------------------------------------------
  initial
  begin
    sda_pull  = 1'b0;
    addr_seen = 8'h00;
    forever
    begin
      @(negedge sda iff scl === 1'b1);
      for (i = 0; i < 8; i++)
      begin
        @(posedge scl);
        sh = {sh[6:0], sda};
      end
      addr_seen = sh;
      @(negedge scl);
      sda_pull = (sh[7:1] == 7'h2A) || (sh[7:1] == 7'h7A); // own address only
      @(negedge scl);
      sda_pull = 1'b0;
      // a 10-bit write header is followed by the low address byte
      if (sh == 8'hF4)
      begin
        for (i = 0; i < 8; i++)
        begin
          @(posedge scl);
          sh = {sh[6:0], sda};
        end
        @(negedge scl);
        sda_pull = (sh == 8'hAA);
        @(negedge scl);
        sda_pull = 1'b0;
      end
      for (k = 0; k < 4 && (sh == 8'h55 || sh == 8'hF5); k++) // at most four bytes, ends early on a nack
      begin
        b = 8'hA5 ^ 8'(k);
        for (i = 7; i >= 0; i--)
        begin
          sda_pull = !b[i]; // msb first
          @(negedge scl);
        end
        sda_pull = 1'b0;
        @(posedge scl);
        if (sda) break; // nack from the master ends the read
        @(negedge scl);
      end
    end
  end
endmodule // imrs_slave

// *** bench/imrs_top_tb.sv ***
// Purpose: self-checking bench for the read sequencer
// Assumes: apb slave answers by pready; slave model on the wire
// Notes:   divider set to its floor to keep the run short
`timescale 1ns/1ns
module imrs_top_tb;
  import imrs_pkg::*;
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, seen;
  logic [31:0] pwdata, prdata, r;
  logic        scl_o, scl_oe, sda_o, sda_oe, irq, pull;
  wire         scl = !scl_oe;        // open drain with pull-up
  wire         sda = !(sda_oe | pull);
  int          n_mismatch, n_checks;
  imrs_top dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
  imrs_slave slv (.scl(scl), .sda(sda), .sda_pull(pull), .addr_seen(seen));
  // ------------------------------------------------------------
  // clock, compare, bus access
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = !core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // this wait ends once pready is seen high; it has no limit of its own
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll a status bit until it reaches the wanted level
  task automatic wait_stat(input int b, input logic v);
    int t;
    t = 0;
    do
    begin
      apb(1'b0, OFF_STAT, 0);
      t++;
    end while (r[b] !== v && t < 1000);
    chk("stat wait", 32'(v), 32'(r[b]));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial
  begin
    #5000000;
    n_mismatch++;
    test_done();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, OFF_DIV, 0);
    chk("div reset", 32'h19, r);
    apb(1'b0, 8'h20, 0);
    chk("unmapped", 32'h1, {r[31:1], pslverr});
    chk("pins low", 32'h0, {30'h0, scl_o, sda_o});
    apb(1'b1, OFF_DIV, 32'h7);
    apb(1'b1, OFF_IMASK, 32'h3);
    apb(1'b1, OFF_DATA, 32'h55);
    apb(1'b1, OFF_CTRL, 32'h3);
    wait_stat(0, 1'b1);
    chk("irq rx", 32'h1, 32'(irq));
    apb(1'b0, OFF_DATA, 0);
    chk("byte 0", 32'hA5, r);
    apb(1'b0, OFF_STAT, 0);
    chk("rx flag clear", 32'h0, 32'(r[0]));
    apb(1'b1, OFF_ISTAT, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h9);
    wait_stat(0, 1'b1);
    apb(1'b0, OFF_DATA, 0);
    chk("byte 1", 32'hA4, r);
    wait_stat(3, 1'b1);
    apb(1'b0, OFF_ISTAT, 0);
    chk("istat", 32'h3, r & 32'h3);
    apb(1'b1, OFF_CTRL, 32'h5);
    wait_stat(4, 1'b0);
    apb(1'b0, OFF_CTRL, 0);
    chk("stop bit", 32'h0, 32'(r[2]));
    apb(1'b0, OFF_ISTAT, 0);
    chk("stop done", 32'hA, r & 32'hA);
    apb(1'b1, OFF_ISTAT, 32'hF);
    // let the clearing edge settle before looking at the level
    @(negedge core_clk);
    chk("irq clear", 32'h0, 32'(irq));
    apb(1'b1, OFF_DATA, 32'hF6);
    apb(1'b1, OFF_CTRL, 32'h33);
    wait_stat(3, 1'b1);
    chk("ack stat", 32'h0, 32'(r[2]));
    chk("first byte", 32'hF6, 32'(seen));
    apb(1'b1, OFF_CTRL, 32'h5);
    wait_stat(4, 1'b0);
    chk("nack clear", 32'h0, 32'(r[3]));
    // 10-bit read: header, low address byte, hardware restart, two bytes
    apb(1'b1, OFF_DATA, 32'hF4);
    apb(1'b1, OFF_CTRL, 32'h33);
    wait_stat(1, 1'b1);
    apb(1'b1, OFF_DATA, 32'hAA);
    wait_stat(0, 1'b1);
    chk("restart byte", 32'hF5, 32'(seen));
    apb(1'b0, OFF_DATA, 0);
    chk("10-bit byte 0", 32'hA5, r);
    apb(1'b1, OFF_CTRL, 32'h9);
    wait_stat(3, 1'b1);
    apb(1'b0, OFF_DATA, 0);
    chk("10-bit byte 1", 32'hA4, r);
    apb(1'b1, OFF_CTRL, 32'h5);
    wait_stat(4, 1'b0);
    test_done();
  end
endmodule // imrs_top_tb
